// ==== dv/tmrcr_other_timer.sv ====
`timescale 1ns/100ps
// stands in for the other timer: one overflow pulse every seven clocks
module tmrcr_other_timer (
    input wire logic sys_clk, // core clock
    input wire logic en, // let pulses out
    output logic ovf // overflow pulse
);
    int n = 0;
    initial ovf = 1'h0;
    always @(posedge sys_clk) begin
        n <= n == 6 ? 0 : n + 1;
        ovf <= #1 en && n == 0;
    end
endmodule // tmrcr_other_timer

// ==== dv/tmrcr_timer_checker.sv ====
`timescale 1ns/100ps
module tmrcr_timer_checker (
    input wire logic sys_clk, // core clock
    input wire logic rst_b, // async reset
    input wire logic [7:0] sfr_addr, // address
    input wire logic [7:0] sfr_wdata, // write data
    input wire logic sfr_wr, // byte write
    input wire logic sfr_bit_wr, // bit write
    input wire logic [7:0] sfr_rdata, // read data
    input wire logic sfr_hit, // decode hit
    input wire logic other_timer_ovf, // other timer
    input wire logic overflow_flag, // bit 7
    input wire logic external_event_flag, // bit 6
    input wire logic irq_req, // request
    input wire logic rx_baud_tick, // receive tick
    input wire logic tx_baud_tick // transmit tick
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire c8 = sfr_addr == 8'hC8;
    wire quiet = !sfr_wr && !sfr_bit_wr;
    a_irq_flags: assert property (irq_req == (overflow_flag | external_event_flag))
        else $error("request does not follow flags");
    a_unmapped_zero: assert property (!sfr_hit |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_flag_bits: assert property (c8 |-> sfr_rdata[7:6] == {overflow_flag, external_event_flag})
        else $error("flag bits differ from flag outputs");
    a_ovf_sticky: assert property (overflow_flag && quiet |=> overflow_flag)
        else $error("overflow flag dropped alone");
    a_ext_sticky: assert property (external_event_flag && quiet |=> external_event_flag)
        else $error("event flag dropped alone");
    a_baud_no_ovf: assert property (c8 && |sfr_rdata[5:4] && !overflow_flag && quiet |=> !overflow_flag)
        else $error("overflow flag set in baud mode");
    a_ctrl_write: assert property (sfr_wr && c8 |=> !c8 || sfr_rdata[5:0] == $past(sfr_wdata[5:0]))
        else $error("control write not visible");
    a_rx_other: assert property (c8 && !sfr_rdata[5] |=> rx_baud_tick == $past(other_timer_ovf))
        else $error("receive tick not from other timer");
    a_tx_other: assert property (c8 && !sfr_rdata[4] |=> tx_baud_tick == $past(other_timer_ovf))
        else $error("transmit tick not from other timer");
endmodule // tmrcr_timer_checker
bind tmrcr_timer tmrcr_timer_checker u_chk (.sys_clk, .rst_b, .sfr_addr, .sfr_wdata, .sfr_wr,
    .sfr_bit_wr, .sfr_rdata, .sfr_hit, .other_timer_ovf, .overflow_flag, .external_event_flag,
    .irq_req, .rx_baud_tick, .tx_baud_tick);

// ==== dv/tmrcr_timer_tb.sv ====
`timescale 1ns/100ps
module tmrcr_timer_tb;
    logic sys_clk = 1'h0, rst_b = 1'h0, sfr_wr = 1'h0, sfr_bit_wr = 1'h0, bval = 1'h0;
    logic trig = 1'h1, cpin = 1'h1, oen = 1'h1, oovf, ovf, exf, irq, rxt, txt, hit, ev, bd;
    logic [7:0] sfr_addr = 8'hC8, sfr_wdata = 8'h00, rdata, m;
    logic [2:0] bsel = 3'h0;
    logic [15:0] r, v, s = 16'h7734;
    int err_count = 0, samples_checked = 0, rx_n, tx_n, k;
    logic [7:0] modes [8] = '{8'h04, 8'h05, 8'h25, 8'h15, 8'h0F, 8'h0E, 8'h07, 8'h3E};
    always #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        rx_n += rxt;
        tx_n += txt;
    end
    tmrcr_other_timer u_oth (.sys_clk(sys_clk), .en(oen), .ovf(oovf));
    tmrcr_timer u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(bsel),
        .sfr_bit_val(bval), .sfr_rdata(rdata), .sfr_hit(hit), .ext_trigger_pin(trig),
        .ext_count_pin(cpin), .other_timer_ovf(oovf), .overflow_flag(ovf),
        .external_event_flag(exf), .irq_req(irq), .rx_baud_tick(rxt), .tx_baud_tick(txt));
    // ==========================================
    // bus and check tasks
    function automatic logic [15:0] rnd();
        s ^= s << 7;
        s ^= s >> 9;
        s ^= s << 8;
        return s;
    endfunction
    task automatic chk(logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // strobes stay up until the next task so no signal is assigned twice in a step
    task automatic idle(int n);
        sfr_wr = 1'h0;
        sfr_bit_wr = 1'h0;
        repeat (n) @(posedge sys_clk) #1;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'h1;
        sfr_bit_wr = 1'h0;
        @(posedge sys_clk) #1;
    endtask
    task automatic bw(logic [2:0] b, logic val);
        sfr_addr = 8'hC8;
        bsel = b;
        bval = val;
        sfr_wr = 1'h0;
        sfr_bit_wr = 1'h1;
        @(posedge sys_clk) #1;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        sfr_addr = a;
        idle(1);
        chk(rdata, e);
    endtask
    task automatic rd16(logic [7:0] a, logic [15:0] e);
        rd(a, e[7:0]);
        rd(a + 8'h01, e[15:8]);
    endtask
    task automatic results();
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ==========================================
    // scenarios
    initial begin
        #300000;
        err_count++;
        results();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst_b = 1'h1;
        idle(8);
        rd(8'hC8, 8'h00);
        rd(8'hC9, 8'h00);
        chk(hit, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            m = 8'hCA + 8'(i);
            v = rnd();
            wr(m, v[7:0]);
            rd(m, v[7:0]);
        end
        oen = 1'h0;
        foreach (modes[i]) begin
            m = modes[i];
            r = rnd();
            v = i < 4 ? 16'hFFFF : rnd() & 16'h7FFF;
            wr(8'hCA, r[7:0]);
            wr(8'hCB, r[15:8]);
            wr(8'hCC, v[7:0]);
            wr(8'hCD, v[15:8]);
            rx_n = 0;
            tx_n = 0;
            bd = m[5] | m[4];
            wr(8'hC8, m);
            if (i < 4) begin
                // stop on the very next edge: exactly one rollover is seen
                wr(8'hC8, m & 8'hFB);
                idle(3);
                rd(8'hC8, {!bd, 7'h00} | (m & 8'hFB));
                chk(irq, !bd);
                rd16(8'hCC, m[0] && !bd ? 16'h0000 : r);
                chk(rx_n, m[5]);
                chk(tx_n, m[4]);
            end else begin
                k = 1 + rnd() % 3;
                repeat (k) begin
                    cpin = 1'h0;
                    idle(4);
                    cpin = 1'h1;
                    idle(4);
                end
                v = v + k;
                trig = 1'h0;
                idle(6);
                trig = 1'h1;
                ev = m[3] && !bd;
                rd(8'hC8, m | {1'h0, ev, 6'h00});
                chk({irq, exf}, {ev, ev});
                rd16(8'hCA, ev && m[0] ? v : r);
                rd16(8'hCC, ev && !m[0] ? r : v);
                bw(3'h6, 1'h0);
                rd(8'hC8, m);
            end
            wr(8'hC8, 8'h00);
            rd(8'hC8, 8'h00);
        end
        results();
    end
endmodule // tmrcr_timer_tb

// ==== rtl/tmrcr_fall_detect.sv ====
`timescale 1ns/100ps

// two-flop synchroniser followed by a falling-edge detector
module tmrcr_fall_detect (
    input wire logic sys_clk, // core clock
    input wire logic rst_b, // async reset, active low
    input wire logic pin_in, // raw pin level
    output logic fall_pulse // one-cycle pulse on high-to-low
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // =====================================================
    // synchroniser; pins idle high so reset to one avoids a false edge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            last_r <= 1'b1;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign fall_pulse = last_r & ~sync_r;

endmodule // tmrcr_fall_detect

// ==== rtl/tmrcr_pkg.sv ====
package tmrcr_pkg;

    // =====================================================
    // special function addresses
    localparam logic [7:0] TMRCR_ADDR_CONTROL = 8'hC8;
    localparam logic [7:0] TMRCR_ADDR_CAP_LOW = 8'hCA;
    localparam logic [7:0] TMRCR_ADDR_CAP_HIGH = 8'hCB;
    localparam logic [7:0] TMRCR_ADDR_COUNT_LOW = 8'hCC;
    localparam logic [7:0] TMRCR_ADDR_COUNT_HIGH = 8'hCD;

    // =====================================================
    // timer_control field positions
    localparam int TMRCR_BIT_OVERFLOW_FLAG = 7;
    localparam int TMRCR_BIT_EXTERNAL_EVENT_FLAG = 6;
    localparam int TMRCR_BIT_RX_CLOCK_SELECT = 5;
    localparam int TMRCR_BIT_TX_CLOCK_SELECT = 4;
    localparam int TMRCR_BIT_EXTERNAL_ENABLE = 3;
    localparam int TMRCR_BIT_RUN_CONTROL = 2;
    localparam int TMRCR_BIT_COUNT_SOURCE_SELECT = 1;
    localparam int TMRCR_BIT_CAPTURE_RELOAD_SELECT = 0;

    // =====================================================
    // reset values and the all-ones rollover count
    localparam logic [7:0] TMRCR_CONTROL_RESET = 8'h00;
    localparam logic [15:0] TMRCR_COUNT_RESET = 16'h0000;
    localparam logic [15:0] TMRCR_CAPTURE_RESET = 16'h0000;
    localparam logic [15:0] TMRCR_COUNT_ALL_ONES = 16'hFFFF;

endpackage

// ==== rtl/tmrcr_timer.sv ====
`timescale 1ns/100ps

// How it works
// - capture mode, no enable: plain timer, overflow flag
// - enabled trigger fall copies count into capture
// - capture also sets external event flag
// - either serial clock select means baud mode
// - baud mode never sets overflow flag
// - baud mode: trigger ignored, external flag not set
// - overflow flag bit 7, software clears
// - external flag bit 6, software clears
// - bit 5 routes our overflow to receive
// - bit 4 routes our overflow to transmit
// - bit 3 enables trigger events
// - bit 2 runs or stops the counter
// - bit 1 picks core clock or pin
// - bit 0 capture or reload, forced reload
// - control at C8, bit addressable, resets 00
// - count bytes at CD and CC
// - capture/reload bytes at CB and CA
// - reload mode rollover reloads, sets flag
// - reload mode trigger reloads, sets flag
module tmrcr_timer
    import tmrcr_pkg::*;
(
    input wire logic sys_clk, // core clock, 200 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic [7:0] sfr_addr, // special function address
    input wire logic [7:0] sfr_wdata, // byte write data
    input wire logic sfr_wr, // byte write strobe
    input wire logic sfr_bit_wr, // single-bit write strobe
    input wire logic [2:0] sfr_bit_sel, // bit number for bit write
    input wire logic sfr_bit_val, // value for bit write
    output logic [7:0] sfr_rdata, // read data for sfr_addr
    output logic sfr_hit, // sfr_addr decodes here
    input wire logic ext_trigger_pin, // external trigger input
    input wire logic ext_count_pin, // external count input
    input wire logic other_timer_ovf, // other timer overflow pulse
    output logic overflow_flag, // timer_control bit 7
    output logic external_event_flag, // timer_control bit 6
    output logic irq_req, // interrupt request level
    output logic rx_baud_tick, // receive clock pulse to serial port
    output logic tx_baud_tick // transmit clock pulse to serial port
);
    // =====================================================
    // state
    logic [7:0] control_r;
    logic [15:0] count_r;
    logic [15:0] capture_r;
    logic [7:0] control_nxt;
    logic trig_fall;
    logic cnt_fall;
    logic baud_mode;
    logic tick;
    logic rollover;
    logic trig_event;
    logic do_reload;
    logic do_capture;
    logic wr_control;
    logic wr_bit_control;
    logic [7:0] wr_value;

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
        return a == ref_a;
    endfunction

    tmrcr_fall_detect u_trig (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(ext_trigger_pin),
        .fall_pulse(trig_fall)
    );

    tmrcr_fall_detect u_cnt (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pin_in(ext_count_pin),
        .fall_pulse(cnt_fall)
    );

    // =====================================================
    // mode decode
    assign baud_mode = control_r[TMRCR_BIT_RX_CLOCK_SELECT]
        | control_r[TMRCR_BIT_TX_CLOCK_SELECT];
    assign tick = control_r[TMRCR_BIT_RUN_CONTROL]
        & (control_r[TMRCR_BIT_COUNT_SOURCE_SELECT] ? cnt_fall : 1'b1);
    assign rollover = tick & (count_r == TMRCR_COUNT_ALL_ONES);
    // the pin is ignored while the timer clocks the serial port
    assign trig_event = trig_fall & control_r[TMRCR_BIT_EXTERNAL_ENABLE]
        & ~baud_mode;
    assign do_capture = trig_event & control_r[TMRCR_BIT_CAPTURE_RELOAD_SELECT];
    // baud mode forces reload on rollover regardless of bit 0
    assign do_reload = (rollover & (baud_mode
        | ~control_r[TMRCR_BIT_CAPTURE_RELOAD_SELECT]))
        | (trig_event & ~control_r[TMRCR_BIT_CAPTURE_RELOAD_SELECT]);

    // =====================================================
    // register writes; bit writes merge into the current control value
    assign wr_control = sfr_wr & addr_is(sfr_addr, TMRCR_ADDR_CONTROL);
    assign wr_bit_control = sfr_bit_wr & addr_is(sfr_addr, TMRCR_ADDR_CONTROL);

    always_comb begin
        wr_value = control_r;
        wr_value[sfr_bit_sel] = sfr_bit_val;
        if (wr_control) begin
            wr_value = sfr_wdata;
        end
        control_nxt = (wr_control | wr_bit_control) ? wr_value : control_r;
        // hardware set wins over a software clear in the same cycle
        if (rollover & ~baud_mode) begin
            control_nxt[TMRCR_BIT_OVERFLOW_FLAG] = 1'b1;
        end
        // the gated trigger also covers the third external interrupt role
        if (trig_event) begin
            control_nxt[TMRCR_BIT_EXTERNAL_EVENT_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            control_r <= TMRCR_CONTROL_RESET;
        end else begin
            control_r <= control_nxt;
        end
    end

    // =====================================================
    // counter; a software byte write takes priority over counting
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_r <= TMRCR_COUNT_RESET;
        end else if (sfr_wr & addr_is(sfr_addr, TMRCR_ADDR_COUNT_LOW)) begin
            count_r[7:0] <= sfr_wdata;
        end else if (sfr_wr & addr_is(sfr_addr, TMRCR_ADDR_COUNT_HIGH)) begin
            count_r[15:8] <= sfr_wdata;
        end else if (do_reload) begin
            count_r <= capture_r;
        end else if (tick) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // =====================================================
    // capture/reload pair; capture overrides a same-cycle write
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            capture_r <= TMRCR_CAPTURE_RESET;
        end else if (do_capture) begin
            capture_r <= count_r;
        end else if (sfr_wr & addr_is(sfr_addr, TMRCR_ADDR_CAP_LOW)) begin
            capture_r[7:0] <= sfr_wdata;
        end else if (sfr_wr & addr_is(sfr_addr, TMRCR_ADDR_CAP_HIGH)) begin
            capture_r[15:8] <= sfr_wdata;
        end
    end

    // =====================================================
    // serial clock routing
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
        end else begin
            rx_baud_tick <= control_r[TMRCR_BIT_RX_CLOCK_SELECT]
                ? rollover : other_timer_ovf;
            tx_baud_tick <= control_r[TMRCR_BIT_TX_CLOCK_SELECT]
                ? rollover : other_timer_ovf;
        end
    end

    // =====================================================
    // read side
    always_comb begin
        sfr_hit = 1'b1;
        unique case (sfr_addr)
            TMRCR_ADDR_CONTROL: sfr_rdata = control_r;
            TMRCR_ADDR_CAP_LOW: sfr_rdata = capture_r[7:0];
            TMRCR_ADDR_CAP_HIGH: sfr_rdata = capture_r[15:8];
            TMRCR_ADDR_COUNT_LOW: sfr_rdata = count_r[7:0];
            TMRCR_ADDR_COUNT_HIGH: sfr_rdata = count_r[15:8];
            default: begin
                sfr_rdata = 8'h00;
                sfr_hit = 1'b0;
            end
        endcase
    end

    assign overflow_flag = control_r[TMRCR_BIT_OVERFLOW_FLAG];
    assign external_event_flag = control_r[TMRCR_BIT_EXTERNAL_EVENT_FLAG];
    assign irq_req = overflow_flag | external_event_flag;

endmodule // tmrcr_timer
